/* File: src/irqep_pkg.sv */
// Constants shared by the interrupt enable, priority and pin edge block.
// Assumes one 25 MHz system clock and an APB register port.
package irqep_pkg;

	localparam int NUM_SRC    = 24;
	localparam int NUM_GROUP  = 6;
	localparam int GROUP_SIZE = 4;
	localparam int NUM_PINS   = 19;
	localparam int NUM_TIMERS = 5;
	localparam int NUM_LEVELS = 4;
	localparam int SYNC_DEPTH = 2;
	localparam int ADDR_W     = 12;
	localparam int IDX_W      = 10;

	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] IDX_FLAGS_LOW   = 10'h0a3;
	localparam logic [IDX_W-1:0] IDX_TIMER_FLAGS = 10'h0a4;
	localparam logic [IDX_W-1:0] IDX_FLAGS_HIGH  = 10'h0a5;
	localparam logic [IDX_W-1:0] IDX_SEL_0_3     = 10'h0a6;
	localparam logic [IDX_W-1:0] IDX_SEL_4_7     = 10'h0a7;
	localparam logic [IDX_W-1:0] IDX_MASK_A      = 10'h0a8;
	localparam logic [IDX_W-1:0] IDX_MASK_B      = 10'h0a9;
	localparam logic [IDX_W-1:0] IDX_MASK_C      = 10'h0aa;
	localparam logic [IDX_W-1:0] IDX_MASK_D      = 10'h0ab;
	localparam logic [IDX_W-1:0] IDX_SEL_8_9_18  = 10'h0ad;
	localparam logic [IDX_W-1:0] IDX_SEL_10_13   = 10'h0ae;
	localparam logic [IDX_W-1:0] IDX_SEL_14_17   = 10'h0af;
	localparam logic [IDX_W-1:0] IDX_LEVEL_LOW   = 10'h0b8;
	localparam logic [IDX_W-1:0] IDX_LEVEL_HIGH  = 10'h0f8;
	localparam logic [IDX_W-1:0] IDX_EVT_STATUS  = 10'h0c0;
	localparam logic [IDX_W-1:0] IDX_EVT_CLEAR   = 10'h0c1;
	localparam logic [IDX_W-1:0] IDX_EVT_ENABLE  = 10'h0c2;

	// Writable bits of each byte register.
	localparam logic [7:0] WMASK_MASK_A  = 8'hbf;
	localparam logic [7:0] WMASK_MASK_BD = 8'h3f;
	localparam logic [7:0] WMASK_MASK_C  = 8'h1f;
	localparam logic [7:0] WMASK_LEVEL   = 8'h3f;
	localparam logic [7:0] WMASK_SEL_1   = 8'h3f;
	localparam logic [7:0] WMASK_FULL    = 8'hff;

	localparam int          GLOBAL_EN_BIT = 7;
	localparam logic [7:0]  RESET_BYTE    = 8'h00;
	localparam logic [23:0] RESET_WORD    = 24'h000000;

	// Sources fed by the flag registers instead of, or as well as, a peripheral.
	localparam int SRC_PINS_0_7    = 5;
	localparam int SRC_TIMER_3_6   = 13;
	localparam int SRC_TIMER_7     = 14;
	localparam int SRC_PINS_8_9_18 = 16;
	localparam int SRC_PINS_10_17  = 23;

	typedef enum logic [1:0] {
		IRQEP_EDGE_NONE = 2'b00,
		IRQEP_EDGE_RISE = 2'b01,
		IRQEP_EDGE_FALL = 2'b10,
		IRQEP_EDGE_BOTH = 2'b11
	} irqep_edge_e;

endpackage

/* File: src/irqep_ctrl.sv */
// Interrupt enable, group priority and external pin edge flag block.
// Assumes peripheral requests and timer events come from sys_clk logic,
// external pins are asynchronous, and the CPU pulses acknowledge and
// return on sys_clk.
`timescale 1ns/1ps

module irqep_ctrl
	import irqep_pkg::*;
(
	// Clock and reset.
	input  wire logic                           sys_clk,
	input  wire logic                           rst_n,
	// APB register port.
	input  wire logic                           psel,
	input  wire logic                           penable,
	input  wire logic                           pwrite,
	input  wire logic [irqep_pkg::ADDR_W-1:0]   paddr,
	input  wire logic [31:0]                    pwdata,
	input  wire logic [3:0]                     pstrb,
	output logic                                pready,
	output logic [31:0]                         prdata,
	output logic                                pslverr,
	// Peripheral requests and timer events.
	input  wire logic [irqep_pkg::NUM_SRC-1:0]  periph_req,
	input  wire logic [irqep_pkg::NUM_TIMERS-1:0] timer_evt,
	// External pins.
	input  wire logic [irqep_pkg::NUM_PINS-1:0] external_pin_irq,
	// CPU side.
	input  wire logic                           cpu_ack,
	input  wire logic                           cpu_reti,
	output logic [irqep_pkg::NUM_SRC-1:0]       cpu_req,
	output logic                                cpu_req_valid,
	output logic [4:0]                          cpu_vec_idx,
	output logic [1:0]                          cpu_req_level,
	// Summary interrupt.
	output logic                                irq_out
);
	import irqep_pkg::*;

	logic [7:0]  enable_mask_a;
	logic [7:0]  enable_mask_b;
	logic [7:0]  enable_mask_c;
	logic [7:0]  enable_mask_d;
	logic [7:0]  group_level_low_bits;
	logic [7:0]  group_level_high_bits;
	logic [7:0]  ext_pin_flags_low;
	logic [7:0]  ext_pin_timer_flags;
	logic [7:0]  ext_pin_flags_high;
	logic [7:0]  edge_select_pins_0_3;
	logic [7:0]  edge_select_pins_4_7;
	logic [7:0]  edge_select_pins_8_9_18;
	logic [7:0]  edge_select_pins_10_13;
	logic [7:0]  edge_select_pins_14_17;
	logic [23:0] evt_status;
	logic [23:0] evt_enable;
	logic [NUM_LEVELS-1:0] in_service;

	logic [NUM_PINS-1:0] pin_sync1;
	logic [NUM_PINS-1:0] pin_sync2;
	logic [NUM_PINS-1:0] pin_prev;
	logic [NUM_PINS-1:0] pin_edge;
	logic [1:0]          pin_edge_code [NUM_PINS];
	logic [SYNC_DEPTH:0] hist_fill;

	logic [IDX_W-1:0] reg_idx;
	logic             access;
	logic             wr_en;
	logic             addr_hit;
	logic [31:0]      next_rdata;
	logic [7:0]       wbyte;

	logic [NUM_SRC-1:0] src_raw;
	logic [NUM_SRC-1:0] src_en;
	logic [NUM_SRC-1:0] pending;
	logic               global_irq_enable;
	logic               next_valid;
	logic [4:0]         next_idx;
	logic [1:0]         next_level;
	logic [1:0]         cur_level;

	assign reg_idx = paddr[ADDR_W-1:2];
	// An access cycle is one that has not yet been answered; ready then
	// closes it for one cycle, so a request that is held is answered every second cycle.
	assign access  = psel & penable & ~pready;
	assign wr_en   = psel & penable & pready & pwrite;
	// Byte registers live in lane 0; a cleared strobe leaves them alone.
	assign wbyte   = pstrb[0] ? pwdata[7:0] : 8'h00;

	// Edge select codes gathered per pin.
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			pin_edge_code[i]      = edge_select_pins_0_3[2*i +: 2];
			pin_edge_code[i + 4]  = edge_select_pins_4_7[2*i +: 2];
			pin_edge_code[i + 10] = edge_select_pins_10_13[2*i +: 2];
			pin_edge_code[i + 14] = edge_select_pins_14_17[2*i +: 2];
		end
		pin_edge_code[8]  = edge_select_pins_8_9_18[1:0];
		pin_edge_code[9]  = edge_select_pins_8_9_18[3:2];
		pin_edge_code[18] = edge_select_pins_8_9_18[5:4];
	end

	// Two-stage synchroniser, then a history stage for edge detection.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pin_sync1 <= '0;
			pin_sync2 <= '0;
			pin_prev  <= '0;
		end else begin
			pin_sync1 <= external_pin_irq;
			pin_sync2 <= pin_sync1;
			pin_prev  <= pin_sync2;
		end
	end

	// The history stage holds a real pin sample only SYNC_DEPTH+1 cycles
	// after reset; until then a pin that idles high would look like a
	// rising edge, so edge detection waits for the fill to complete.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			hist_fill <= '0;
		end else begin
			hist_fill <= {hist_fill[SYNC_DEPTH-1:0], 1'b1};
		end
	end

	genvar gp;
	generate
		for (gp = 0; gp < NUM_PINS; gp++) begin : g_edge
			logic rise;
			logic fall;
			assign rise = pin_sync2[gp] & ~pin_prev[gp];
			assign fall = ~pin_sync2[gp] & pin_prev[gp];
			assign pin_edge[gp] = hist_fill[SYNC_DEPTH] &
				((pin_edge_code[gp][0] & rise) |
				(pin_edge_code[gp][1] & fall));
		end
	endgenerate

	// Control registers.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			enable_mask_a           <= RESET_BYTE;
			enable_mask_b           <= RESET_BYTE;
			enable_mask_c           <= RESET_BYTE;
			enable_mask_d           <= RESET_BYTE;
			group_level_low_bits    <= RESET_BYTE;
			group_level_high_bits   <= RESET_BYTE;
			edge_select_pins_0_3    <= RESET_BYTE;
			edge_select_pins_4_7    <= RESET_BYTE;
			edge_select_pins_8_9_18 <= RESET_BYTE;
			edge_select_pins_10_13  <= RESET_BYTE;
			edge_select_pins_14_17  <= RESET_BYTE;
		end else if (wr_en && pstrb[0]) begin
			case (reg_idx)
				IDX_MASK_A: enable_mask_a <= wbyte & WMASK_MASK_A;
				IDX_MASK_B: enable_mask_b <= wbyte & WMASK_MASK_BD;
				IDX_MASK_C: enable_mask_c <= wbyte & WMASK_MASK_C;
				IDX_MASK_D: enable_mask_d <= wbyte & WMASK_MASK_BD;
				IDX_LEVEL_LOW: group_level_low_bits <= wbyte & WMASK_LEVEL;
				IDX_LEVEL_HIGH: group_level_high_bits <= wbyte & WMASK_LEVEL;
				IDX_SEL_0_3: edge_select_pins_0_3 <= wbyte;
				IDX_SEL_4_7: edge_select_pins_4_7 <= wbyte;
				IDX_SEL_8_9_18: edge_select_pins_8_9_18 <= wbyte & WMASK_SEL_1;
				IDX_SEL_10_13: edge_select_pins_10_13 <= wbyte;
				IDX_SEL_14_17: edge_select_pins_14_17 <= wbyte;
				default: ;
			endcase
		end
	end

	// Flags: writing zero clears, writing one keeps, a new edge always sets.
	// A clear and an edge in the same cycle leave the flag set, so an event
	// that lands while software clears an older one is never lost.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			ext_pin_flags_low   <= RESET_BYTE;
			ext_pin_timer_flags <= RESET_BYTE;
			ext_pin_flags_high  <= RESET_BYTE;
		end else begin
			ext_pin_flags_low <= ((wr_en && pstrb[0] &&
				reg_idx == IDX_FLAGS_LOW) ? (ext_pin_flags_low & wbyte) :
				ext_pin_flags_low) | pin_edge[7:0];
			ext_pin_timer_flags <= ((wr_en && pstrb[0] &&
				reg_idx == IDX_TIMER_FLAGS) ?
				(ext_pin_timer_flags & wbyte) : ext_pin_timer_flags) |
				{timer_evt, pin_edge[18], pin_edge[9], pin_edge[8]};
			ext_pin_flags_high <= ((wr_en && pstrb[0] &&
				reg_idx == IDX_FLAGS_HIGH) ? (ext_pin_flags_high & wbyte) :
				ext_pin_flags_high) | pin_edge[17:10];
		end
	end

	// Request sources and their enables.
	// Pin and timer flags replace or join the peripheral level for the
	// sources that they feed; the other sources pass straight through.
	assign global_irq_enable = enable_mask_a[GLOBAL_EN_BIT];

	always_comb begin
		src_raw = periph_req;
		src_raw[SRC_PINS_0_7]    = |ext_pin_flags_low;
		src_raw[SRC_TIMER_3_6]   = periph_req[SRC_TIMER_3_6] |
			(|ext_pin_timer_flags[6:3]);
		src_raw[SRC_TIMER_7]     = periph_req[SRC_TIMER_7] |
			ext_pin_timer_flags[7];
		src_raw[SRC_PINS_8_9_18] = |ext_pin_timer_flags[2:0];
		src_raw[SRC_PINS_10_17]  = |ext_pin_flags_high;
		src_en = {enable_mask_d[5:0], enable_mask_c[5:0],
			enable_mask_b[5:0], enable_mask_a[5:0]};
		pending = src_raw & src_en & {NUM_SRC{global_irq_enable}};
	end

	// Level of the routine now running, highest in-service bit.
	always_comb begin
		cur_level = 2'b00;
		for (int l = 0; l < NUM_LEVELS; l++) begin
			if (in_service[l]) begin
				cur_level = 2'(l);
			end
		end
	end

	// Pick the highest level; strict compare keeps the lower index on ties.
	// The level only rises on the way up the list, so the first source seen
	// at the winning level is the lowest numbered one.
	always_comb begin
		logic       found;
		logic [1:0] lvl;
		found      = 1'b0;
		lvl        = 2'b00;
		next_idx   = 5'h00;
		next_level = 2'b00;
		for (int s = 0; s < NUM_SRC; s++) begin
			lvl = {group_level_high_bits[s / GROUP_SIZE],
				group_level_low_bits[s / GROUP_SIZE]};
			if (pending[s] && (!found || lvl > next_level)) begin
				found      = 1'b1;
				next_idx   = 5'(s);
				next_level = lvl;
			end
		end
		next_valid = found && (in_service == '0 ||
			next_level > cur_level);
	end

	// CPU facing request outputs.
	// An accepted request drops valid for a cycle, which gives the nesting
	// record time to take the new level before the next decision.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cpu_req       <= '0;
			cpu_req_valid <= 1'b0;
			cpu_vec_idx   <= 5'h00;
			cpu_req_level <= 2'b00;
		end else begin
			cpu_req       <= pending;
			cpu_req_valid <= next_valid & ~cpu_ack;
			cpu_vec_idx   <= next_idx;
			cpu_req_level <= next_level;
		end
	end

	// Nesting record: acknowledge enters a level, return leaves the top one.
	// A return and an acknowledge in one cycle close the old top level
	// first, so the newly accepted level is never cleared by mistake.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			in_service <= '0;
		end else begin
			logic [NUM_LEVELS-1:0] nxt;
			nxt = in_service;
			if (cpu_reti && in_service != '0) begin
				nxt[cur_level] = 1'b0;
			end
			if (cpu_ack && cpu_req_valid) begin
				nxt[cpu_req_level] = 1'b1;
			end
			in_service <= nxt;
		end
	end

	// Sticky event status, write-one clear, enable and summary line.
	// The status follows the enabled requests, so a clear that meets a
	// request still standing leaves the bit set.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			evt_status <= RESET_WORD;
			evt_enable <= RESET_WORD;
			irq_out    <= 1'b0;
		end else begin
			logic [23:0] clr;
			clr = '0;
			if (wr_en && reg_idx == IDX_EVT_CLEAR) begin
				for (int b = 0; b < 3; b++) begin
					if (pstrb[b]) begin
						clr[8*b +: 8] = pwdata[8*b +: 8];
					end
				end
			end
			if (wr_en && reg_idx == IDX_EVT_ENABLE) begin
				for (int b = 0; b < 3; b++) begin
					if (pstrb[b]) begin
						evt_enable[8*b +: 8] <= pwdata[8*b +: 8];
					end
				end
			end
			evt_status <= (evt_status & ~clr) | pending;
			irq_out    <= |(evt_status & evt_enable);
		end
	end

	// Read data and decode.
	// Reads of unmapped indices return zero with an error response.
	always_comb begin
		addr_hit   = 1'b1;
		next_rdata = 32'h00000000;
		case (reg_idx)
			IDX_FLAGS_LOW:   next_rdata[7:0] = ext_pin_flags_low;
			IDX_TIMER_FLAGS: next_rdata[7:0] = ext_pin_timer_flags;
			IDX_FLAGS_HIGH:  next_rdata[7:0] = ext_pin_flags_high;
			IDX_SEL_0_3:     next_rdata[7:0] = edge_select_pins_0_3;
			IDX_SEL_4_7:     next_rdata[7:0] = edge_select_pins_4_7;
			IDX_MASK_A:      next_rdata[7:0] = enable_mask_a;
			IDX_MASK_B:      next_rdata[7:0] = enable_mask_b;
			IDX_MASK_C:      next_rdata[7:0] = enable_mask_c;
			IDX_MASK_D:      next_rdata[7:0] = enable_mask_d;
			IDX_SEL_8_9_18:  next_rdata[7:0] = edge_select_pins_8_9_18;
			IDX_SEL_10_13:   next_rdata[7:0] = edge_select_pins_10_13;
			IDX_SEL_14_17:   next_rdata[7:0] = edge_select_pins_14_17;
			IDX_LEVEL_LOW:   next_rdata[7:0] = group_level_low_bits;
			IDX_LEVEL_HIGH:  next_rdata[7:0] = group_level_high_bits;
			IDX_EVT_STATUS:  next_rdata[23:0] = evt_status;
			IDX_EVT_CLEAR:   next_rdata = 32'h00000000;
			IDX_EVT_ENABLE:  next_rdata[23:0] = evt_enable;
			default:         addr_hit = 1'b0;
		endcase
	end

	// One wait state: ready rises in the second access cycle.
	// Read data is captured only for reads, so it holds between reads.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= access;
			pslverr <= access & ~addr_hit;
			if (access && !pwrite) begin
				prdata <= next_rdata;
			end
		end
	end

endmodule

/* File: verif/irqep_ctrl_assertions.sv */
// Port-level checker for the interrupt controller.
// Sees only the controller's ports; attached by the bind at the foot.
`timescale 1ns/1ps
module irqep_ctrl_assertions
	import irqep_pkg::*;
(
	// Clock, reset and register port.
	input wire logic                         sys_clk,
	input wire logic                         rst_n,
	input wire logic                         psel,
	input wire logic                         penable,
	input wire logic                         pwrite,
	input wire logic [irqep_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                  pwdata,
	input wire logic [3:0]                   pstrb,
	input wire logic                         pready,
	input wire logic [31:0]                  prdata,
	input wire logic                         pslverr,
	// Sources.
	input wire logic [23:0]                  periph_req,
	input wire logic [4:0]                   timer_evt,
	input wire logic [18:0]                  external_pin_irq,
	// CPU side.
	input wire logic                         cpu_ack,
	input wire logic                         cpu_reti,
	input wire logic [23:0]                  cpu_req,
	input wire logic                         cpu_req_valid,
	input wire logic [4:0]                   cpu_vec_idx,
	input wire logic [1:0]                   cpu_req_level,
	input wire logic                         irq_out
);
	logic [23:0] below;
	// Bit positions of the winner's group that sit below the winner.
	assign below = ((24'h1 << cpu_vec_idx) - 24'h1) &
		~((24'h1 << {cpu_vec_idx[4:2], 2'b00}) - 24'h1);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	a_reset_quiet: assert property (disable iff (1'b0)
		!rst_n |=> !pready && cpu_req == 24'h0 && !cpu_req_valid && !irq_out)
		else $error("outputs not cleared by reset");
	a_apb_answer: assert property (
		psel && penable && !pready |=> pready)
		else $error("no answer one cycle after access");
	a_ready_pulse: assert property (
		pready |=> !pready)
		else $error("ready held over two cycles");
	a_err_with_ready: assert property (
		pslverr |-> pready && (pwrite || prdata == 32'h0))
		else $error("error response malformed");
	a_winner_pending: assert property (
		cpu_req_valid |-> cpu_req[cpu_vec_idx] && (cpu_req & below) == 24'h0)
		else $error("winner not the lowest pending in its group");
	a_ack_drops: assert property (
		cpu_ack && cpu_req_valid |=> !cpu_req_valid)
		else $error("request stayed valid after acceptance");
	a_preempt_higher: assert property (
		cpu_ack && cpu_req_valid ##1 !cpu_reti ##1 cpu_req_valid
		|-> cpu_req_level > $past(cpu_req_level, 2))
		else $error("preemption by a level not strictly higher");
	a_no_source17: assert property (
		cpu_req[17] == 1'b0)
		else $error("unused source presented");
endmodule
bind irqep_ctrl irqep_ctrl_assertions u_irqep_ctrl_assertions (
	.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.pready(pready), .prdata(prdata), .pslverr(pslverr),
	.periph_req(periph_req), .timer_evt(timer_evt),
	.external_pin_irq(external_pin_irq), .cpu_ack(cpu_ack),
	.cpu_reti(cpu_reti), .cpu_req(cpu_req), .cpu_req_valid(cpu_req_valid),
	.cpu_vec_idx(cpu_vec_idx), .cpu_req_level(cpu_req_level),
	.irq_out(irq_out));

/* File: verif/irqep_cpu_model.sv */
// Behavioural CPU core that accepts requests and returns from service.
// Assumes the controller's request outputs are registered on sys_clk.
`timescale 1ns/1ps
module irqep_cpu_model (
	// Clock, reset and run control.
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic go,
	// Request handshake.
	input  wire logic cpu_req_valid,
	output logic      cpu_ack,
	output logic      cpu_reti
);
	logic [2:0] depth;
	logic [3:0] tick;
	// Service length follows a free counter, so returns come prompt or slow.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cpu_ack  <= 1'b0;
			cpu_reti <= 1'b0;
			depth    <= 3'h0;
			tick     <= 4'h0;
		end else begin
			tick     <= tick + 4'h1;
			cpu_ack  <= go && cpu_req_valid && !cpu_ack;
			cpu_reti <= go && depth != 3'h0 && tick[2:0] == 3'h5 && !cpu_reti;
			depth    <= depth + {2'h0, cpu_ack} - {2'h0, cpu_reti};
		end
	end
endmodule

/* File: verif/tb.sv */
// Self-checking bench for the interrupt controller.
// Drives APB, pins, timers and requests; a CPU model accepts requests.
`timescale 1ns/1ps
module tb;
	import irqep_pkg::*;
	logic        sys_clk, rst_n, psel, penable, pwrite, go, pready, pslverr;
	logic        cpu_ack, cpu_reti, cpu_req_valid, irq_out;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, sd;
	logic [3:0]  pstrb;
	logic [23:0] periph_req, cpu_req, er;
	logic [4:0]  timer_evt, cpu_vec_idx, tf, bi;
	logic [18:0] pins, ef, nw;
	logic [1:0]  cpu_req_level, bl;
	logic [37:0] cv;
	logic [32:0] exq[$];
	int          bad_count, n_tests;
	localparam logic [9:0] RI [17] = '{IDX_FLAGS_LOW, IDX_TIMER_FLAGS,
		IDX_FLAGS_HIGH, IDX_SEL_0_3, IDX_SEL_4_7, IDX_MASK_A, IDX_MASK_B,
		IDX_MASK_C, IDX_MASK_D, IDX_SEL_8_9_18, IDX_SEL_10_13, IDX_SEL_14_17,
		IDX_LEVEL_LOW, IDX_LEVEL_HIGH, IDX_EVT_STATUS, IDX_EVT_CLEAR,
		IDX_EVT_ENABLE};
	localparam logic [23:0] WM [17] = '{24'h0, 24'h0, 24'h0, 24'hff, 24'hff,
		24'hbf, 24'h3f, 24'h1f, 24'h3f, 24'h3f, 24'hff, 24'hff, 24'h3f,
		24'h3f, 24'h0, 24'h0, 24'hffffff};
	irqep_ctrl u_irqep_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.periph_req(periph_req), .timer_evt(timer_evt),
		.external_pin_irq(pins), .cpu_ack(cpu_ack), .cpu_reti(cpu_reti),
		.cpu_req(cpu_req), .cpu_req_valid(cpu_req_valid),
		.cpu_vec_idx(cpu_vec_idx), .cpu_req_level(cpu_req_level),
		.irq_out(irq_out));
	irqep_cpu_model u_irqep_cpu_model (.sys_clk(sys_clk), .rst_n(rst_n),
		.go(go), .cpu_req_valid(cpu_req_valid), .cpu_ack(cpu_ack),
		.cpu_reti(cpu_reti));
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		lfsr = s;
		repeat (16)
			lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
	endfunction
	task automatic chk(input string nm, input logic [32:0] e, g);
		n_tests++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// One APB transfer; a read leaves its expected {error, data} in the queue.
	task automatic apb(input logic w, input logic [9:0] i,
		input logic [23:0] d, input logic [32:0] e);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {i, 2'b00};
		pwdata <= {8'h00, d};
		if (!w)
			exq.push_back(e);
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
			k++;
		end while (!pready && k < 40);
		if (k >= 40) begin
			bad_count++;
			print_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic wr(input logic [9:0] i, input logic [23:0] d);
		apb(1'b1, i, d, 33'h0);
	endtask
	task automatic rd(input logic [9:0] i, input logic [32:0] e);
		apb(1'b0, i, 24'h0, e);
	endtask
	always @(posedge sys_clk)
		if (psel && penable && pready && !pwrite)
			chk("read", exq.pop_front(), {pslverr, prdata});
	task automatic rd_flags();
		rd(IDX_FLAGS_LOW, {25'h0, ef[7:0]});
		rd(IDX_TIMER_FLAGS, {25'h0, tf, ef[18], ef[9], ef[8]});
		rd(IDX_FLAGS_HIGH, {25'h0, ef[17:10]});
	endtask
	task automatic pin_round();
		for (int r = 0; r < 4; r++) begin
			sd = lfsr(sd);
			nw = sd[18:0];
			for (int n = 0; n < 19; n++)
				ef[n] |= (cv[2*n] & !pins[n] & nw[n]) |
					(cv[2*n+1] & pins[n] & !nw[n]);
			pins <= nw;
			wait_cyc(6);
		end
	endtask
	initial begin
		{psel, penable, pwrite, go} = 4'h0;
		{paddr, pwdata, periph_req} = 68'h0;
		{timer_evt, pins, ef, tf} = 48'h0;
		pstrb = 4'hf;
		rst_n = 1'b0;
		bad_count = 0;
		n_tests = 0;
		sd = 32'h000152f0;
		wait_cyc(2);
		rst_n <= 1'b1;
		wait_cyc(1);
		for (int k = 0; k < 17; k++) begin
			rd(RI[k], 33'h0);
			wr(RI[k], 24'hffffff);
			rd(RI[k], {9'h0, WM[k]});
			wr(RI[k], 24'h0);
		end
		rd(10'h3ff, {1'b1, 32'h0});
		for (int q = 0; q < 3; q++) begin
			sd = lfsr(sd);
			cv[31:0] = sd;
			sd = lfsr(sd);
			cv[37:32] = sd[5:0];
			wr(IDX_SEL_0_3, {16'h0, cv[7:0]});
			wr(IDX_SEL_4_7, {16'h0, cv[15:8]});
			wr(IDX_SEL_8_9_18, {18'h0, cv[37:36], cv[19:16]});
			wr(IDX_SEL_10_13, {16'h0, cv[27:20]});
			wr(IDX_SEL_14_17, {16'h0, cv[35:28]});
			pin_round();
			sd = lfsr(sd);
			timer_evt <= sd[4:0];
			tf |= sd[4:0];
			wait_cyc(1);
			timer_evt <= 5'h0;
			wait_cyc(3);
			rd_flags();
			sd = lfsr(sd);
			wr(IDX_FLAGS_LOW, {16'h0, sd[7:0]});
			wr(IDX_TIMER_FLAGS, {16'h0, sd[15:8]});
			wr(IDX_FLAGS_HIGH, {16'h0, sd[23:16]});
			ef &= {sd[10], sd[23:16], sd[9:8], sd[7:0]};
			tf &= sd[15:11];
			rd_flags();
		end
		wr(IDX_FLAGS_LOW, 24'h0);
		wr(IDX_TIMER_FLAGS, 24'h0);
		wr(IDX_FLAGS_HIGH, 24'h0);
		wr(IDX_SEL_0_3, 24'h3);
		wr(IDX_MASK_A, 24'ha0);
		pins[0] <= !pins[0];
		wait_cyc(4);
		chk("req", 33'h0, {9'h0, cpu_req});
		wait_cyc(1);
		chk("req", {9'h0, 24'h20}, {9'h0, cpu_req});
		wait_cyc(1);
		chk("irq", 33'h0, {32'h0, irq_out});
		rd(IDX_EVT_STATUS, 33'h20);
		wr(IDX_EVT_ENABLE, 24'h20);
		wait_cyc(2);
		chk("irq", 33'h1, {32'h0, irq_out});
		wr(IDX_MASK_A, 24'h20);
		wait_cyc(2);
		chk("req", 33'h0, {9'h0, cpu_req});
		wr(IDX_EVT_CLEAR, 24'h20);
		wait_cyc(2);
		chk("irq", 33'h0, {32'h0, irq_out});
		rd(IDX_FLAGS_LOW, 33'h1);
		wr(IDX_FLAGS_LOW, 24'h0);
		wr(IDX_MASK_A, 24'hbf);
		wr(IDX_MASK_B, 24'h3f);
		wr(IDX_MASK_C, 24'h1f);
		wr(IDX_MASK_D, 24'h3f);
		for (int q = 0; q < 8; q++) begin
			sd = lfsr(sd);
			wr(IDX_LEVEL_LOW, {18'h0, sd[5:0]});
			wr(IDX_LEVEL_HIGH, {18'h0, sd[13:8]});
			periph_req <= sd[31:8];
			wait_cyc(3);
			er = sd[31:8] & 24'h7cffdf;
			bl = 2'h0;
			bi = 5'h0;
			for (int n = 23; n >= 0; n--)
				if (er[n] && {sd[8+n/4], sd[n/4]} >= bl) begin
					bl = {sd[8+n/4], sd[n/4]};
					bi = n[4:0];
				end
			chk("req", {9'h0, er}, {9'h0, cpu_req});
			chk("valid", {32'h0, |er}, {32'h0, cpu_req_valid});
			chk("vec", {28'h0, bi}, {28'h0, cpu_vec_idx});
			chk("level", {31'h0, bl}, {31'h0, cpu_req_level});
		end
		go <= 1'b1;
		for (int q = 0; q < 40; q++) begin
			sd = lfsr(sd);
			periph_req <= sd[23:0];
			wait_cyc(8);
		end
		go <= 1'b0;
		wait_cyc(4);
		print_verdict();
	end
endmodule
